// ---- hdl/dfc_top.sv ----
// Distributor function control register and the logic it steers.
// Assumes a single-cycle strobe register port and one clock domain.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Serialize on: remote set/clear delivered before write response.
// - Serialize off: hold set/clear locally, forward later; resets zero.
// - Powerdown-deny bit rejects every powerdown request.
// - Cache-correction-disable bit alters memory-port cache attributes.
// - Two-bit error shared-interrupt access value, secure access only.
// - Ten clock-gate override bits; 1 keeps region clocked.
// - Override bits map to fixed regions, bit 9 reserved; code keeps bit 9 writable and drives CLK_KEEP_O[9].
// - Scrub bit is RW, reads 1 while running, self-clears when done.
// - Scrub covers local RAMs only; never forwarded off-chip.
module dfc_top #(
  parameter int NUM_RAMS = 4
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic        SECURE_I,
  output logic      [31:0] RDATA_O,
  // Shared-interrupt set/clear requests from the slave port
  input  wire logic        SPI_REQ_I,
  input  wire logic        SPI_EDGE_I,
  input  wire logic        SPI_REMOTE_I,
  output logic             SPI_RESP_O,
  output logic             REMOTE_REQ_O,
  input  wire logic        REMOTE_ACK_I,
  output logic             SPI_PENDING_O,
  // Power handshake
  input  wire logic        QREQ_N_I,
  output logic             QACCEPT_N_O,
  output logic             POWERDOWN_DENY_O,
  // Memory attributes
  input  wire logic [3:0]  CACHE_CORR_I,
  input  wire logic [3:0]  CACHE_RAW_I,
  output logic      [3:0]  CACHE_O,
  // Region controls
  output logic      [1:0]  ERR_NS_ACCESS_O,
  output logic      [9:0]  CLK_KEEP_O,
  output logic [NUM_RAMS-1:0] RAM_SCRUB_O
);
  // The scrub sequencer counts banks in four bits
  if (NUM_RAMS < 1 || NUM_RAMS > 16) begin : g_bad_rams
    $error("NUM_RAMS must lie between 1 and 16");
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] rdata, next_rdata;
  logic        hit;
  dfc_scrub_if sc();

  assign hit = (ADDR_I == dfc_pkg::DFC_REG_OFFSET);

  always_comb begin
    logic [31:0] m;
    m = dfc_pkg::WR_MASK;
    if (!SECURE_I) m = m & ~dfc_pkg::SEC_MASK;
    next_ctrl = ctrl;
    if (WR_I && hit) begin
      next_ctrl = (ctrl & ~m) | (WDATA_I & m);
    end
    // A running scrub keeps the bit up even if software writes 0
    if (sc.busy) begin
      next_ctrl[dfc_pkg::SCRUB_BIT] = 1'b1;
    end
    // Completion wins only when not restarted in the same cycle
    if (sc.done && !(WR_I && hit && WDATA_I[dfc_pkg::SCRUB_BIT])) begin
      next_ctrl[dfc_pkg::SCRUB_BIT] = 1'b0;
    end
    next_rdata = 32'h0;
    if (RD_I && hit) begin
      next_rdata = ctrl & dfc_pkg::WR_MASK;
      if (!SECURE_I) begin
        next_rdata = next_rdata & ~dfc_pkg::SEC_MASK;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      ctrl  <= dfc_pkg::DFC_RESET;
      rdata <= 32'h0;
    end else begin
      ctrl  <= next_ctrl;
      rdata <= next_rdata;
    end
  end
  assign RDATA_O = rdata;

  // ----------------------------------------------------------------------
  // Scrub start: local sequencer only, nothing leaves the chip
  // ----------------------------------------------------------------------
  // Start whenever the bit is up and the sequencer is free; the done
  // cycle is skipped so a finished scrub is not launched again, while a
  // rewrite of 1 in that cycle still starts a fresh scrub after it
  assign sc.start = ctrl[dfc_pkg::SCRUB_BIT] && !sc.busy
                    && !sc.done;

  dfc_scrub_seq #(.NUM_RAMS(NUM_RAMS)) u_scrub (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RST_N_I),
    .sc          (sc.eng),
    .ram_scrub_o (RAM_SCRUB_O)
  );

  // ----------------------------------------------------------------------
  // Shared-interrupt set/clear forwarding
  // ----------------------------------------------------------------------
  dfc_pkg::dfc_fwd_state_t st, next_st;
  logic pend, next_pend;
  logic resp, next_resp;
  logic rreq, next_rreq;
  logic fwd_remote;
  assign fwd_remote = SPI_REQ_I && SPI_EDGE_I && SPI_REMOTE_I;

  always_comb begin
    next_st   = st;
    next_pend = pend;
    next_resp = 1'b0;
    next_rreq = rreq;
    case (st)
      dfc_pkg::DFC_IDLE: begin
        if (fwd_remote && ctrl[dfc_pkg::POS_BIT]) begin
          next_st   = dfc_pkg::DFC_SEND;
          next_rreq = 1'b1;
        end else if (fwd_remote) begin
          next_pend = 1'b1;
          next_resp = 1'b1;
        end else if (pend) begin
          next_st   = dfc_pkg::DFC_WAIT;
          next_rreq = 1'b1;
        end else if (SPI_REQ_I) begin
          next_resp = 1'b1;
        end
      end
      dfc_pkg::DFC_SEND: begin
        if (REMOTE_ACK_I) begin
          next_st   = dfc_pkg::DFC_IDLE;
          next_rreq = 1'b0;
          next_resp = 1'b1;
        end
      end
      dfc_pkg::DFC_WAIT: begin
        if (REMOTE_ACK_I) begin
          next_st   = dfc_pkg::DFC_IDLE;
          next_rreq = 1'b0;
          next_pend = 1'b0;
        end
      end
      default: begin
        next_st   = dfc_pkg::DFC_IDLE;
        next_rreq = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      st   <= dfc_pkg::DFC_IDLE;
      pend <= 1'b0;
      resp <= 1'b0;
      rreq <= 1'b0;
    end else begin
      st   <= next_st;
      pend <= next_pend;
      resp <= next_resp;
      rreq <= next_rreq;
    end
  end
  assign SPI_RESP_O    = resp;
  assign REMOTE_REQ_O  = rreq;
  assign SPI_PENDING_O = pend;

  // ----------------------------------------------------------------------
  // Power handshake: pin input synchronised, deny overrides acceptance
  // ----------------------------------------------------------------------
  logic [2:0] qs, next_qs;
  logic       qreq, next_qreq;
  logic       acc_n, next_acc_n;
  logic       deny, next_deny;

  always_comb begin
    next_qs   = {qs[1:0], QREQ_N_I};
    next_qreq = (qs[2] == qs[1]) ? ~qs[2] : qreq;
    next_acc_n = 1'b1;
    next_deny  = 1'b0;
    if (qreq) begin
      if (ctrl[dfc_pkg::POWERDOWN_DENY_BIT]) begin
        next_deny = 1'b1;
      end else begin
        next_acc_n = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      qs    <= 3'h7;
      qreq  <= 1'b0;
      acc_n <= 1'b1;
      deny  <= 1'b0;
    end else begin
      qs    <= next_qs;
      qreq  <= next_qreq;
      acc_n <= next_acc_n;
      deny  <= next_deny;
    end
  end
  assign QACCEPT_N_O = acc_n;
  assign POWERDOWN_DENY_O     = deny;

  // ----------------------------------------------------------------------
  // Attribute and region outputs
  // ----------------------------------------------------------------------
  assign CACHE_O = ctrl[dfc_pkg::DCC_BIT] ? CACHE_RAW_I
                                          : CACHE_CORR_I;
  assign ERR_NS_ACCESS_O =
    ctrl[dfc_pkg::NSA_LSB +: dfc_pkg::NSA_W];
  // Bit 0 CPU comms, 1 shared regs, 2 slave, 3 master, 4 message cache,
  // 5 sw-generated/redistributor, 6 trace, 7 pending search, 8 translation
  assign CLK_KEEP_O =
    ctrl[dfc_pkg::CGO_LSB +: dfc_pkg::CGO_W];
endmodule
`default_nettype wire

// ---- hdl/dfc_pkg.sv ----
// Package for the distributor function control register block.
// Assumes a single 32-bit register reached over a plain strobe port.
package dfc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  DFC_REG_OFFSET   = 8'h00;
  localparam logic [31:0] DFC_RESET        = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SCRUB_BIT        = 0;
  localparam int CGO_LSB          = 4;
  localparam int CGO_W            = 10;
  localparam int NSA_LSB          = 16;
  localparam int NSA_W            = 2;
  localparam int DCC_BIT          = 21;
  localparam int POWERDOWN_DENY_BIT        = 25;
  localparam int POS_BIT          = 26;

  // Writable bits; everything else reads zero
  localparam logic [31:0] WR_MASK  = 32'h0623_3ff1;
  localparam logic [31:0] SEC_MASK = 32'h0003_0000;

  // ----------------------------------------------------------------------
  // Forwarding engine states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DFC_IDLE = 2'b00,
    DFC_SEND = 2'b01,
    DFC_WAIT = 2'b11
  } dfc_fwd_state_t;

  localparam logic [3:0] SCRUB_CYCLES = 4'hf;

endpackage

// ---- hdl/dfc_scrub_if.sv ----
// Interface between the register block and the scrub sequencer.
// Assumes both ends share the distributor clock.
`timescale 1ns/1ps
`default_nettype none
interface dfc_scrub_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport eng  (input start, output busy, output done);
endinterface
`default_nettype wire

// ---- hdl/dfc_scrub_seq.sv ----
// Local scrub sequencer: walks every local RAM bank, then reports done.
// Assumes each bank scrub takes a fixed number of cycles.
`timescale 1ns/1ps
`default_nettype none
module dfc_scrub_seq #(
  parameter int NUM_RAMS = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  dfc_scrub_if.eng        sc,
  output logic [NUM_RAMS-1:0] ram_scrub_o
);
  // Bank index is four bits wide
  if (NUM_RAMS < 1 || NUM_RAMS > 16) begin : g_bad_rams
    $error("NUM_RAMS out of range");
  end

  logic       busy, next_busy;
  logic [3:0] bank, next_bank;
  logic [3:0] cnt, next_cnt;
  logic       done, next_done;

  always_comb begin
    next_busy = busy;
    next_bank = bank;
    next_cnt  = cnt;
    next_done = 1'b0;
    if (!busy && sc.start) begin
      next_busy = 1'b1;
      next_bank = 4'h0;
      next_cnt  = dfc_pkg::SCRUB_CYCLES;
    end else if (busy) begin
      if (cnt != 4'h0) begin
        next_cnt = cnt - 4'h1;
      end else if (bank == 4'(NUM_RAMS - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_bank = bank + 4'h1;
        next_cnt  = dfc_pkg::SCRUB_CYCLES;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      bank <= 4'h0;
      cnt  <= 4'h0;
      done <= 1'b0;
    end else begin
      busy <= next_busy;
      bank <= next_bank;
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

  assign sc.busy = busy;
  assign sc.done = done;
  for (genvar g = 0; g < NUM_RAMS; g++) begin : g_bank
    assign ram_scrub_o[g] = busy && (bank == 4'(g));
  end
endmodule
`default_nettype wire

// ---- tb/dfc_chk.sv ----
// Port checker for the function control register block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dfc_chk #(
  parameter int NUM_RAMS = 4
) (
  input wire logic                CORE_CLK_I,
  input wire logic                RST_N_I,
  input wire logic [7:0]          ADDR_I,
  input wire logic [31:0]         WDATA_I,
  input wire logic                WR_I,
  input wire logic                RD_I,
  input wire logic                SECURE_I,
  input wire logic [31:0]         RDATA_O,
  input wire logic                SPI_RESP_O,
  input wire logic                REMOTE_REQ_O,
  input wire logic                REMOTE_ACK_I,
  input wire logic                SPI_PENDING_O,
  input wire logic                QREQ_N_I,
  input wire logic                QACCEPT_N_O,
  input wire logic                POWERDOWN_DENY_O,
  input wire logic [1:0]          ERR_NS_ACCESS_O,
  input wire logic [9:0]          CLK_KEEP_O,
  input wire logic [NUM_RAMS-1:0] RAM_SCRUB_O
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic wr0;
  logic rd0;
  assign wr0 = WR_I && (ADDR_I == dfc_pkg::DFC_REG_OFFSET);
  assign rd0 = RD_I && (ADDR_I == dfc_pkg::DFC_REG_OFFSET);
  keep_wr_a: assert property (wr0 |=>
    CLK_KEEP_O == $past(WDATA_I[13:4]))
    else $error("keep field not loaded");
  nsa_wr_a: assert property (wr0 && SECURE_I |=>
    ERR_NS_ACCESS_O == $past(WDATA_I[17:16]))
    else $error("error access field not loaded");
  nsa_lock_a: assert property (wr0 && !SECURE_I |=>
    $stable(ERR_NS_ACCESS_O))
    else $error("non-secure write changed access field");
  rsvd_rd_a: assert property (RD_I |=>
    (RDATA_O & ~dfc_pkg::WR_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  deny_acc_a: assert property (POWERDOWN_DENY_O |-> QACCEPT_N_O)
    else $error("powerdown accepted while denied");
  q_answer_a: assert property ((!QREQ_N_I) [*8] |->
    !QACCEPT_N_O || POWERDOWN_DENY_O)
    else $error("powerdown request unanswered");
  resp_early_a: assert property (REMOTE_REQ_O &&
    !SPI_PENDING_O && !REMOTE_ACK_I |=> !SPI_RESP_O)
    else $error("response before remote delivery");
  resp_late_a: assert property (REMOTE_REQ_O &&
    !SPI_PENDING_O && REMOTE_ACK_I |-> ##[1:2] SPI_RESP_O)
    else $error("no response after remote delivery");
  pend_fwd_a: assert property ($rose(SPI_PENDING_O) |->
    ##[0:4] REMOTE_REQ_O)
    else $error("stored request not forwarded");
  bank_one_a: assert property ($onehot0(RAM_SCRUB_O))
    else $error("more than one bank under scrub");
  scrub_busy_a: assert property (rd0 && (|RAM_SCRUB_O) |=>
    RDATA_O[0])
    else $error("scrub bit low while scrub running");
  cover property (SPI_RESP_O && !SPI_PENDING_O);
  cover property (POWERDOWN_DENY_O);
  cover property (|RAM_SCRUB_O);
  cover property ($fell(|RAM_SCRUB_O));
endmodule
bind dfc_top dfc_chk #(.NUM_RAMS(NUM_RAMS)) i_dfc_chk (.*);
`default_nettype wire

// ---- tb/dfc_top_tb.sv ----
// Self-checking bench for the function control register block.
// Assumes dfc_top with its default bank count.
`timescale 1ns/1ps
`default_nettype none
module dfc_top_tb;
  logic clk, rst_n, wr, rd, sec, spi_req, spi_edge, spi_rem, rem_ack;
  logic qreq_n, spi_resp, rem_req, pend, qacc_n, powerdown_deny;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  corr, raw, cache;
  logic [1:0]  ns_acc;
  logic [9:0]  keep;
  logic [3:0]  scrub;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_resp = 0;
  dfc_top i_dfc_top (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .SECURE_I(sec), .RDATA_O(rdata),
    .SPI_REQ_I(spi_req), .SPI_EDGE_I(spi_edge), .SPI_REMOTE_I(spi_rem),
    .SPI_RESP_O(spi_resp), .REMOTE_REQ_O(rem_req), .REMOTE_ACK_I(rem_ack),
    .SPI_PENDING_O(pend), .QREQ_N_I(qreq_n), .QACCEPT_N_O(qacc_n),
    .POWERDOWN_DENY_O(powerdown_deny), .CACHE_CORR_I(corr), .CACHE_RAW_I(raw), .CACHE_O(cache),
    .ERR_NS_ACCESS_O(ns_acc), .CLK_KEEP_O(keep), .RAM_SCRUB_O(scrub));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (spi_resp === 1'b1) n_resp++;
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reg_wr(input logic [31:0] d, input logic s);
    addr <= 8'h00;
    wdata <= d;
    sec <= s;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_rd(output logic [31:0] d, input logic s);
    addr <= 8'h00;
    sec <= s;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic spi_go();
    spi_req <= 1'b1;
    @(posedge clk);
    spi_req <= 1'b0;
    cyc(3);
  endtask
  task automatic ack();
    rem_ack <= 1'b1;
    @(posedge clk);
    rem_ack <= 1'b0;
    cyc(3);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_scrub();
    logic [31:0] d;
    logic        seen;
    int          i;
    seen = 1'b0;
    reg_rd(d, 1'b1);
    chk("reset_val", 32'h0, d);
    reg_wr(32'h1, 1'b1);
    reg_rd(d, 1'b1);
    chk("scrub_on", 32'h1, d);
    reg_wr(32'h0, 1'b1);
    reg_rd(d, 1'b1);
    chk("scrub_hold", 32'h1, d);
    for (i = 0; i < 100 && d[0] === 1'b1; i++) begin
      seen = seen | (|scrub);
      reg_rd(d, 1'b1);
    end
    chk("scrub_bank", 32'h1, {31'h0, seen});
    chk("scrub_off", 32'h0, d);
    if (d[0] !== 1'b0) give_verdict();
  endtask
  task automatic t_fields();
    logic [31:0] d;
    reg_wr(32'hffff_fffe, 1'b1);
    reg_rd(d, 1'b1);
    chk("reg_all", 32'h0623_3ff0, d);
    chk("keep_all", 32'h3ff, {22'h0, keep});
    reg_wr(32'h0, 1'b0);
    reg_rd(d, 1'b1);
    chk("ns_keep", 32'h0003_0000, d);
    chk("ns_out", 32'h3, {30'h0, ns_acc});
    reg_rd(d, 1'b0);
    chk("ns_hide", 32'h0, d);
    for (int i = 4; i < 14; i++) begin
      reg_wr(32'h1 << i, 1'b1);
      chk("keep_map", 32'h1 << (i - 4), {22'h0, keep});
    end
    reg_wr(32'h0000_2000, 1'b1);
    chk("keep_rsvd", 32'h200, {22'h0, keep});
  endtask
  task automatic t_misc();
    raw <= 4'h5;
    corr <= 4'ha;
    reg_wr(32'h0220_0000, 1'b1);
    chk("cache_raw", 32'h5, {28'h0, cache});
    qreq_n <= 1'b0;
    cyc(8);
    chk("deny", 32'h3, {30'h0, powerdown_deny, qacc_n});
    qreq_n <= 1'b1;
    cyc(8);
    reg_wr(32'h0, 1'b1);
    chk("cache_corr", 32'ha, {28'h0, cache});
    qreq_n <= 1'b0;
    cyc(8);
    chk("accept", 32'h0, {30'h0, powerdown_deny, qacc_n});
    qreq_n <= 1'b1;
    cyc(8);
  endtask
  task automatic t_spi();
    reg_wr(32'h0400_0000, 1'b1);
    n_resp = 0;
    spi_go();
    chk("pos_wait", 32'h2, {rem_req, n_resp[0]});
    ack();
    chk("pos_done", 32'h1, {rem_req, n_resp[0]});
    spi_edge <= 1'b0;
    n_resp = 0;
    spi_go();
    chk("level_resp", 32'h1, {rem_req, n_resp[0]});
    spi_edge <= 1'b1;
    reg_wr(32'h0, 1'b1);
    n_resp = 0;
    spi_go();
    chk("local_resp", 32'h1, n_resp);
    chk("local_fwd", 32'h3, {30'h0, pend, rem_req});
    ack();
    chk("local_done", 32'h0, {30'h0, pend, rem_req});
  endtask
  initial begin
    {addr, wdata, wr, rd, sec, spi_req, rem_ack, corr, raw} = '0;
    {spi_edge, spi_rem, qreq_n} = 3'h7;
    rst_n = 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset_acc", 32'h1, {31'h0, qacc_n});
    t_scrub();
    t_fields();
    t_misc();
    t_spi();
    give_verdict();
  end
endmodule
`default_nettype wire
